//--- bench/rss_link_checker.sv
// Protocol checker on the RTC serial link wires
`include "rss_map.svh"
module rss_link_checker (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic h_sda_oe,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_reg, sda_reg, first_reg, rd_reg, rise, start, stop, match;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  assign rise = scl && !scl_reg;
  assign start = scl && scl_reg && sda_reg && !sda;
  assign stop = scl && scl_reg && !sda_reg && sda;
  assign match = (sh_reg[7:1] == `RSS_ID_RTC) || (sh_reg[7:1] == `RSS_ID_USR);
  ////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk_i) begin
    scl_reg <= srst_i ? 1'b1 : scl;
    sda_reg <= srst_i ? 1'b1 : sda;
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i || start || stop) begin
      cnt_reg <= 4'h0;
    end else if (rise) begin
      cnt_reg <= (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      first_reg <= 1'b0;
    end else if (start) begin
      first_reg <= 1'b1;
    end else if (rise && cnt_reg == 4'h9) begin
      first_reg <= 1'b0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_reg <= 1'b0;
    end else if (rise && first_reg && cnt_reg == 4'h7) begin
      rd_reg <= sda;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rise && cnt_reg != 4'h8) begin
      sh_reg <= {sh_reg[6:0], sda};
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);
  property p_dev_moves_low;
    $changed(d_sda_oe) |-> !scl;
  endproperty
  a_dev_moves_low: assert property (p_dev_moves_low)
    else $error("slave changed SDA while SCL high");
  property p_id_ack;
    rise && first_reg && cnt_reg == 4'h8 |-> d_sda_oe == match;
  endproperty
  a_id_ack: assert property (p_id_ack)
    else $error("identification byte ack wrong");
  property p_wr_ack;
    rise && !first_reg && !rd_reg && cnt_reg == 4'h8 |-> d_sda_oe;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write byte not acked");
  property p_rd_release;
    rise && !first_reg && rd_reg && cnt_reg == 4'h8 |-> !d_sda_oe;
  endproperty
  a_rd_release: assert property (p_rd_release)
    else $error("slave holds SDA in master ack slot");
  property p_rd_host_quiet;
    rise && !first_reg && rd_reg && cnt_reg inside {[4'h1:4'h7]} |-> !h_sda_oe;
  endproperty
  a_rd_host_quiet: assert property (p_rd_host_quiet)
    else $error("master drives SDA during read data");
  property p_nack_release;
    rise && !first_reg && rd_reg && cnt_reg == 4'h8 && sda |-> ##1 (!d_sda_oe) [*8];
  endproperty
  a_nack_release: assert property (p_nack_release)
    else $error("slave drives SDA after master no-ack");
  property p_stop_idle;
    stop |-> !d_sda_oe ##1 !d_sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("slave drives SDA at STOP");
  property p_start_quiet;
    start |-> !d_sda_oe;
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("slave drives SDA at START");
endmodule // rss_link_checker

//--- bench/rtc_serial_slave_transactions_tb_top.sv
// Self-checking bench joining master and slave ends of the RTC serial link
`include "rss_map.svh"
module rtc_serial_slave_transactions_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic cmd_valid_i = 1'b0, cmd_rd_i = 1'b0, cmd_usr_i = 1'b0, ld_stb_i = 1'b0, ld_usr_i = 1'b0;
  logic [7:0] cmd_addr_i = 8'h00, cmd_data_i = 8'h00, cmd_len_i = 8'h01;
  logic [7:0] ld_addr_i = 8'h00, ld_data_i = 8'h00;
  logic cmd_ready_o, rsp_valid_o, done_o, nack_o, wr_stb_o, wr_usr_o, rd_stb_o, busy_o;
  logic [7:0] rsp_data_o, wr_addr_o, wr_data_o;
  logic [7:0] mem [2][128];
  logic [8:0] wq[$];
  logic [7:0] rq[$];
  logic scl_q = 1'b1, sda_q = 1'b1;
  logic [3:0] bc = 4'h0;
  logic [8:0] sh = 9'h000;
  int err_count = 0, n_tests = 0, wr_seen = 0, rd_seen = 0;
  rss_link_if lnk();
  rss_host rss_host_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .lnk(lnk),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_rd_i(cmd_rd_i),
    .cmd_usr_i(cmd_usr_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
    .cmd_len_i(cmd_len_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .done_o(done_o), .nack_o(nack_o));
  rss_dev rss_dev_inst (.core_clk_i(core_clk_i), .srst_i(srst_i), .lnk(lnk),
    .ld_stb_i(ld_stb_i), .ld_usr_i(ld_usr_i), .ld_addr_i(ld_addr_i), .ld_data_i(ld_data_i),
    .wr_stb_o(wr_stb_o), .wr_usr_o(wr_usr_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .rd_stb_o(rd_stb_o), .busy_o(busy_o));
  rss_link_checker rss_link_checker_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .h_sda_oe(lnk.h_sda_oe), .d_sda_oe(lnk.d_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 core_clk_i = ~core_clk_i;
  end
  // Wire monitor: each byte with its ack bit, plus user-side strobes
  always @(negedge core_clk_i) begin
    if (lnk.scl && scl_q && sda_q != lnk.sda) begin
      bc = 4'h0;
    end else if (lnk.scl && !scl_q) begin
      bc = (bc == 4'h9) ? 4'h1 : bc + 4'h1;
      sh = {sh[7:0], lnk.sda};
      if (bc == 4'h9) begin
        wq.push_back(sh);
      end
    end
    if (rsp_valid_o === 1'b1) begin
      rq.push_back(rsp_data_o);
    end
    if (wr_stb_o === 1'b1) begin
      wr_seen++;
    end
    if (rd_stb_o === 1'b1) begin
      rd_seen++;
    end
    scl_q = lnk.scl;
    sda_q = lnk.sda;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [7:0] idb(input logic usr, input logic rd);
    return {usr ? `RSS_ID_USR : `RSS_ID_RTC, rd};
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic run_cmd(input logic rd, input logic usr, input logic [7:0] a,
      input logic [7:0] d, input logic [7:0] n);
    int k;
    wq.delete();
    rq.delete();
    wr_seen = 0;
    rd_seen = 0;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_rd_i <= rd;
    cmd_usr_i <= usr;
    cmd_addr_i <= a;
    cmd_data_i <= d;
    cmd_len_i <= n;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    k = 0;
    while (done_o !== 1'b1 && k < 20000) begin
      @(negedge core_clk_i);
      k++;
    end
    if (k >= 20000) begin
      check(9'h000, 9'h001);
      print_verdict();
    end
    repeat (4) @(negedge core_clk_i);
  endtask
  task automatic load(input logic usr, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    ld_stb_i <= 1'b1;
    ld_usr_i <= usr;
    ld_addr_i <= a;
    ld_data_i <= d;
    mem[usr][a] = d;
    @(posedge core_clk_i);
    ld_stb_i <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    @(negedge core_clk_i);
    check(9'(busy_o), 9'h000);
    check(9'(cmd_ready_o), 9'h001);
    check(9'(lnk.d_sda_oe), 9'h000);
  endtask
  task automatic t_write(input logic usr, input logic [7:0] a, input logic [7:0] d);
    run_cmd(1'b0, usr, a, d, 8'h01);
    mem[usr][a] = d;
    check(9'(wq.size()), 9'h003);
    check(wq[0], {idb(usr, 1'b0), 1'b0});
    check(wq[1], {a, 1'b0});
    check(wq[2], {d, 1'b0});
    check(9'(wr_seen), 9'h001);
    check({wr_usr_o, wr_addr_o}, {usr, a});
    check(9'(wr_data_o), 9'(d));
    check(9'(nack_o), 9'h000);
    check(9'(busy_o), 9'h000);
  endtask
  task automatic t_read(input logic usr, input logic [7:0] a, input logic [7:0] n);
    logic [7:0] p;
    run_cmd(1'b1, usr, a, 8'h00, n);
    p = a;
    check(9'(wq.size()), 9'(n) + 9'h003);
    check(wq[0], {idb(usr, 1'b0), 1'b0});
    check(wq[1], {a, 1'b0});
    check(wq[2], {idb(usr, 1'b1), 1'b0});
    for (int i = 0; i < n; i++) begin
      check(wq[i + 3], {mem[usr][p], i == n - 1});
      check(9'(rq[i]), 9'(mem[usr][p]));
      p = (p == (usr ? `RSS_USR_LAST : `RSS_RTC_LAST)) ? `RSS_PTR_RST : p + 8'h01;
    end
    check(9'(nack_o), 9'h000);
    check(9'(rd_seen), 9'(n));
    check(9'(busy_o), 9'h000);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'b0;
    t_reset();
    t_write(1'b0, 8'h05, 8'hA5);
    t_write(1'b1, 8'h7F, 8'h3C);
    load(1'b0, 8'h12, 8'hC1);
    load(1'b0, 8'h13, 8'h82);
    load(1'b0, 8'h00, 8'h4D);
    load(1'b0, 8'h01, 8'h1E);
    load(1'b1, 8'h00, 8'h96);
    t_read(1'b0, 8'h12, 8'h04);
    t_read(1'b1, 8'h7F, 8'h02);
    t_read(1'b0, 8'h05, 8'h01);
    print_verdict();
  end
endmodule // rtc_serial_slave_transactions_tb_top

//--- src/rss_dev.sv
// Slave end: RTC serial transaction logic with register and SRAM arrays
`include "rss_map.svh"
module rss_dev (
  input wire logic core_clk_i,
  input wire logic srst_i,
  rss_link_if.dev lnk,
  input wire logic ld_stb_i,
  input wire logic ld_usr_i,
  input wire logic [7:0] ld_addr_i,
  input wire logic [7:0] ld_data_i,
  output logic wr_stb_o,
  output logic wr_usr_o,
  output logic [7:0] wr_addr_o,
  output logic [7:0] wr_data_o,
  output logic rd_stb_o,
  output logic busy_o
);
  ////////////////////////////////////////////////////////////////////////////
  // Storage and state
  logic [7:0] rtc_mem [0:`RSS_RTC_DEPTH-1];
  logic [7:0] usr_mem [0:`RSS_USR_DEPTH-1];
  logic [1:0] sync1_reg;
  logic [1:0] sync2_reg;
  logic [1:0] dly_reg;
  rss_pkg::rss_dstate_e state_reg;
  rss_pkg::rss_dstate_e ret_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic [3:0] bit_cnt_reg;
  logic usr_reg;
  logic mack_reg;
  logic sda_oe_reg;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic byte_in;
  logic wr_now;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [7:0] ptr_inc(input logic [7:0] p, input logic usr);
    logic [7:0] last;
    last = usr ? `RSS_USR_LAST : `RSS_RTC_LAST;
    ptr_inc = (p >= last) ? `RSS_PTR_RST : p + 8'h01;
  endfunction

  function automatic logic id_hit(input logic [7:0] b);
    id_hit = (b[7:1] == `RSS_ID_RTC) || (b[7:1] == `RSS_ID_USR);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus conditions
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync1_reg <= 2'h3;
      sync2_reg <= 2'h3;
      dly_reg <= 2'h3;
    end else begin
      sync1_reg <= {lnk.scl, lnk.sda};
      sync2_reg <= sync1_reg;
      dly_reg <= sync2_reg;
    end
  end

  assign scl_s = sync2_reg[1];
  assign sda_s = sync2_reg[0];
  assign scl_rise = scl_s && !dly_reg[1];
  assign scl_fall = !scl_s && dly_reg[1];
  assign start_det = scl_s && dly_reg[1] && dly_reg[0] && !sda_s;
  assign stop_det = scl_s && dly_reg[1] && !dly_reg[0] && sda_s;
  assign byte_in = scl_fall && (bit_cnt_reg == `RSS_BYTE_BITS);
  assign wr_now = (state_reg == rss_pkg::DS_WDATA) && byte_in && !start_det && !stop_det;

  ////////////////////////////////////////////////////////////////////////////
  // Read data at the pointer
  always_comb begin
    if (usr_reg) begin
      rd_byte = usr_mem[ptr_reg[6:0]];
    end else if (ptr_reg <= `RSS_RTC_LAST) begin
      rd_byte = rtc_mem[ptr_reg[4:0]];
    end else begin
      rd_byte = 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory writes, link first, then local load
  always_ff @(posedge core_clk_i) begin
    if (wr_now) begin
      if (usr_reg) begin
        usr_mem[ptr_reg[6:0]] <= shift_reg;
      end else if (ptr_reg <= `RSS_RTC_LAST) begin
        rtc_mem[ptr_reg[4:0]] <= shift_reg;
      end
    end else if (ld_stb_i) begin
      if (ld_usr_i) begin
        usr_mem[ld_addr_i[6:0]] <= ld_data_i;
      end else if (ld_addr_i <= `RSS_RTC_LAST) begin
        rtc_mem[ld_addr_i[4:0]] <= ld_data_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction state machine
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= rss_pkg::DS_IDLE;
      ret_reg <= rss_pkg::DS_IDLE;
      shift_reg <= 8'h00;
      ptr_reg <= `RSS_PTR_RST;
      bit_cnt_reg <= 4'h0;
      usr_reg <= 1'b0;
      mack_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= rss_pkg::DS_DEV;
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= rss_pkg::DS_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        rss_pkg::DS_IDLE, rss_pkg::DS_WAIT: begin
          sda_oe_reg <= 1'b0;
        end
        rss_pkg::DS_DEV, rss_pkg::DS_ADDR, rss_pkg::DS_WDATA: begin
          if (scl_rise && (bit_cnt_reg < `RSS_BYTE_BITS)) begin
            shift_reg <= {shift_reg[6:0], sda_s};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_in) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == rss_pkg::DS_DEV) begin
              if (id_hit(shift_reg)) begin
                sda_oe_reg <= 1'b1;
                state_reg <= rss_pkg::DS_ACK;
                usr_reg <= (shift_reg[7:1] == `RSS_ID_USR);
                ret_reg <= shift_reg[0] ? rss_pkg::DS_RDATA : rss_pkg::DS_ADDR;
              end else begin
                state_reg <= rss_pkg::DS_WAIT;
              end
            end else if (state_reg == rss_pkg::DS_ADDR) begin
              ptr_reg <= shift_reg;
              sda_oe_reg <= 1'b1;
              state_reg <= rss_pkg::DS_ACK;
              ret_reg <= rss_pkg::DS_WDATA;
            end else begin
              ptr_reg <= ptr_inc(ptr_reg, usr_reg);
              sda_oe_reg <= 1'b1;
              state_reg <= rss_pkg::DS_ACK;
              ret_reg <= rss_pkg::DS_IDLE;
            end
          end
        end
        rss_pkg::DS_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            state_reg <= ret_reg;
            if (ret_reg == rss_pkg::DS_RDATA) begin
              shift_reg <= rd_byte;
              sda_oe_reg <= !rd_byte[7];
            end else begin
              sda_oe_reg <= 1'b0;
            end
          end
        end
        rss_pkg::DS_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt_reg == `RSS_LAST_BIT) begin
              sda_oe_reg <= 1'b0;
              state_reg <= rss_pkg::DS_RACK;
              ptr_reg <= ptr_inc(ptr_reg, usr_reg);
            end else begin
              shift_reg <= {shift_reg[6:0], 1'b0};
              sda_oe_reg <= !shift_reg[6];
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        rss_pkg::DS_RACK: begin
          if (scl_rise) begin
            mack_reg <= !sda_s;
          end else if (scl_fall) begin
            if (mack_reg) begin
              shift_reg <= rd_byte;
              sda_oe_reg <= !rd_byte[7];
              bit_cnt_reg <= 4'h0;
              state_reg <= rss_pkg::DS_RDATA;
            end else begin
              sda_oe_reg <= 1'b0;
              state_reg <= rss_pkg::DS_WAIT;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // User-side strobes
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wr_stb_o <= 1'b0;
      wr_usr_o <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 8'h00;
      rd_stb_o <= 1'b0;
    end else begin
      wr_stb_o <= wr_now;
      rd_stb_o <= (state_reg == rss_pkg::DS_RDATA) && scl_fall && !start_det
        && !stop_det && (bit_cnt_reg == `RSS_LAST_BIT);
      if (wr_now) begin
        wr_usr_o <= usr_reg;
        wr_addr_o <= ptr_reg;
        wr_data_o <= shift_reg;
      end
    end
  end

  assign busy_o = (state_reg != rss_pkg::DS_IDLE);
  assign lnk.d_sda_o = 1'b0;
  assign lnk.d_sda_oe = sda_oe_reg;
endmodule // rss_dev

//--- src/rss_host.sv
// Master end: issues byte writes and sequential reads on the link
`include "rss_map.svh"
module rss_host (
  input wire logic core_clk_i,
  input wire logic srst_i,
  rss_link_if.host lnk,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_rd_i,
  input wire logic cmd_usr_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_data_i,
  input wire logic [7:0] cmd_len_i,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o,
  output logic done_o,
  output logic nack_o
);
  ////////////////////////////////////////////////////////////////////////////
  // State
  rss_pkg::rss_hstate_e st_reg;
  logic [7:0] div_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] addr_reg;
  logic [7:0] data_reg;
  logic [7:0] left_reg;
  logic [6:0] id_reg;
  logic rd_reg;
  logic nack_reg;
  logic scl_oe_reg;
  logic sda_oe_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic tick;
  logic tx;
  logic byte_end;

  assign tick = (div_reg == 8'h00);
  assign tx = (st_reg != rss_pkg::HS_RDATA);
  assign byte_end = tick && (q_reg == 2'h3) && (bit_reg == `RSS_BYTE_BITS);
  assign cmd_ready_o = (st_reg == rss_pkg::HS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Quarter-bit divider and SDA synchroniser
  always_ff @(posedge core_clk_i) begin
    if (srst_i || tick) begin
      div_reg <= 8'(`RSS_QCNT - 1);
    end else begin
      div_reg <= div_reg - 8'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= lnk.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit sequencer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_reg <= rss_pkg::HS_IDLE;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      shift_reg <= 8'h00;
      addr_reg <= 8'h00;
      data_reg <= 8'h00;
      left_reg <= 8'h00;
      id_reg <= `RSS_ID_RTC;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (st_reg == rss_pkg::HS_IDLE) begin
      q_reg <= 2'h0;
      if (cmd_valid_i) begin
        st_reg <= rss_pkg::HS_START;
        id_reg <= cmd_usr_i ? `RSS_ID_USR : `RSS_ID_RTC;
        rd_reg <= cmd_rd_i;
        addr_reg <= cmd_addr_i;
        data_reg <= cmd_data_i;
        left_reg <= (cmd_len_i == 8'h00) ? 8'h01 : cmd_len_i;
        nack_reg <= 1'b0;
      end
    end else if (tick) begin
      q_reg <= q_reg + 2'h1;
      unique case (st_reg)
        rss_pkg::HS_START, rss_pkg::HS_RSTART: begin
          unique case (q_reg)
            2'h0: sda_oe_reg <= 1'b0;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b1;
            2'h3: begin
              scl_oe_reg <= 1'b1;
              bit_reg <= 4'h0;
              shift_reg <= {id_reg, st_reg == rss_pkg::HS_RSTART};
              st_reg <= (st_reg == rss_pkg::HS_START) ? rss_pkg::HS_DEVW : rss_pkg::HS_DEVR;
            end
          endcase
        end
        rss_pkg::HS_STOP: begin
          unique case (q_reg)
            2'h0: sda_oe_reg <= 1'b1;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b0;
            2'h3: st_reg <= rss_pkg::HS_IDLE;
          endcase
        end
        default: begin
          unique case (q_reg)
            2'h0: begin
              if (bit_reg < `RSS_BYTE_BITS) begin
                sda_oe_reg <= tx && !shift_reg[7];
              end else begin
                sda_oe_reg <= !tx && (left_reg > 8'h01);
              end
            end
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: begin
              if (bit_reg < `RSS_BYTE_BITS) begin
                shift_reg <= {shift_reg[6:0], !tx && sda_s2_reg};
              end else if (tx) begin
                nack_reg <= sda_s2_reg;
              end
            end
            2'h3: begin
              scl_oe_reg <= 1'b1;
              bit_reg <= bit_reg + 4'h1;
              if (bit_reg == `RSS_BYTE_BITS) begin
                bit_reg <= 4'h0;
                if (tx && nack_reg) begin
                  st_reg <= rss_pkg::HS_STOP;
                end else begin
                  unique case (st_reg)
                    rss_pkg::HS_DEVW: begin
                      shift_reg <= addr_reg;
                      st_reg <= rss_pkg::HS_ADDR;
                    end
                    rss_pkg::HS_ADDR: begin
                      shift_reg <= data_reg;
                      st_reg <= rd_reg ? rss_pkg::HS_RSTART : rss_pkg::HS_WDATA;
                    end
                    rss_pkg::HS_DEVR: st_reg <= rss_pkg::HS_RDATA;
                    rss_pkg::HS_RDATA: begin
                      left_reg <= left_reg - 8'h01;
                      if (left_reg <= 8'h01) begin
                        st_reg <= rss_pkg::HS_STOP;
                      end
                    end
                    default: st_reg <= rss_pkg::HS_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Responses
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      done_o <= 1'b0;
    end else begin
      rsp_valid_o <= byte_end && (st_reg == rss_pkg::HS_RDATA);
      if (byte_end && (st_reg == rss_pkg::HS_RDATA)) begin
        rsp_data_o <= shift_reg;
      end
      done_o <= tick && (q_reg == 2'h3) && (st_reg == rss_pkg::HS_STOP);
    end
  end

  assign nack_o = nack_reg;
  assign lnk.scl_o = 1'b0;
  assign lnk.scl_oe = scl_oe_reg;
  assign lnk.h_sda_o = 1'b0;
  assign lnk.h_sda_oe = sda_oe_reg;
endmodule // rss_host

//--- src/rss_link_if.sv
// Open-drain SCL and SDA wires between master and slave
interface rss_link_if;
  logic scl_o;
  logic scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // Pull-ups win unless a driver pulls low
  assign scl = (scl_oe && !scl_o) ? 1'b0 : 1'b1;
  assign sda = ((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o)) ? 1'b0 : 1'b1;
  modport host (output scl_o, output scl_oe, output h_sda_o, output h_sda_oe,
    input scl, input sda);
  modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

//--- src/rss_map.svh
// Constants and timing counts of the RTC serial link
`ifndef RSS_MAP_SVH
`define RSS_MAP_SVH
`define RSS_ID_RTC 7'h6F
`define RSS_ID_USR 7'h57
`define RSS_RTC_LAST 8'h13
`define RSS_USR_LAST 8'h7F
`define RSS_PTR_RST 8'h00
`define RSS_RTC_DEPTH 20
`define RSS_USR_DEPTH 128
`define RSS_BYTE_BITS 4'h8
`define RSS_LAST_BIT 4'h7
`define RSS_CLK_NS 25
`define RSS_SCL_NS 2500
`define RSS_QCNT ((`RSS_SCL_NS / `RSS_CLK_NS) / 4)
`endif

//--- src/rss_pkg.sv
// State types of both ends of the RTC serial link, one enum per end
package rss_pkg;
  typedef enum logic [2:0] {
    DS_IDLE = 3'h0,
    DS_DEV = 3'h1,
    DS_ADDR = 3'h2,
    DS_WDATA = 3'h3,
    DS_ACK = 3'h4,
    DS_RDATA = 3'h5,
    DS_RACK = 3'h6,
    DS_WAIT = 3'h7
  } rss_dstate_e;
  typedef enum logic [3:0] {
    HS_IDLE = 4'h0,
    HS_START = 4'h1,
    HS_DEVW = 4'h2,
    HS_ADDR = 4'h3,
    HS_WDATA = 4'h4,
    HS_RSTART = 4'h5,
    HS_DEVR = 4'h6,
    HS_RDATA = 4'h7,
    HS_STOP = 4'h8
  } rss_hstate_e;
endpackage
